// *** lfm_pkg.sv ***
// Package for the LED matrix fault monitor: offsets, fields, resets, types
package lfm_pkg;

  // ---------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------
  localparam int NUM_SW     = 12;
  localparam int DUTY_WIDTH = 12;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 16;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFF_OPEN_BYPASS_OVERRIDE   = 8'h09;
  localparam logic [7:0] OFF_FAULT_MASK_CONFIG      = 8'h0C;
  localparam logic [7:0] OFF_GENERAL_STATUS         = 8'h10;
  localparam logic [7:0] OFF_SHORT_FAULT_STATUS     = 8'h12;
  localparam logic [7:0] OFF_OPEN_FAULT_STATUS      = 8'h13;
  localparam logic [7:0] OFF_SHORT_FILTER_DUTY_LIMIT = 8'h16;

  // ---------------------------------------------------------------------
  // Field positions in fault_mask_config
  // ---------------------------------------------------------------------
  localparam int MSK_OPEN_BIT    = 0;
  localparam int MSK_SHORT_BIT   = 1;
  localparam int MSK_THERM_BIT   = 2;
  localparam int MSK_GRADE_BIT   = 3;
  localparam int MSK_SERIAL_BIT  = 4;
  localparam int SHDN_ACTION_BIT = 5;

  // Field positions in general_status
  localparam int STAT_WARN_BIT   = 0;
  localparam int STAT_SHDN_BIT   = 1;
  localparam int STAT_GRADE_BIT  = 2;
  localparam int STAT_CRC_BIT    = 3;
  localparam int STAT_PAR_BIT    = 4;
  localparam int STAT_STOP_BIT   = 5;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] RST_MASK       = 16'h0000;
  localparam logic [11:0] RST_OVERRIDE   = 12'h000;
  localparam logic [11:0] RST_DUTY_LIMIT = 12'h000;
  localparam logic [15:0] RST_STATUS     = 16'h0000;
  localparam logic [11:0] DUTY_FULL      = 12'hFFF;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    THERM_NORMAL   = 2'b00,
    THERM_SHUTDOWN = 2'b01
  } lfm_therm_type;

  // Register access request from the serial engine
  typedef struct packed {
    logic                  wrEn;
    logic                  rdEn;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
  } lfm_req_type;

  // Serial receive error events, one-cycle pulses
  typedef struct packed {
    logic crcErr;
    logic parityErr;
    logic stopErr;
  } lfm_rxerr_type;

endpackage

// *** lfm_switch_qual.sv ***
// Per-switch qualification of open and short comparators
`timescale 1ns/1ns
module lfm_switch_qual
  import lfm_pkg::*;
#(
  parameter int DW = DUTY_WIDTH
) (
  input  wire logic          clk,          // System clock
  input  wire logic          rst_b,        // Async reset, active low
  input  wire logic          clkEn,        // Freezes state when low
  input  wire logic [DW-1:0] duty,         // Programmed duty value
  input  wire logic [DW-1:0] dutyLimit,    // Short filter duty limit
  input  wire logic          swOpen,       // Switch in open phase
  input  wire logic          openCmp,      // Drain-source above open level
  input  wire logic          shortCmp,     // Drain-source below short level
  output logic               openEvent,    // Open fault seen this cycle
  output logic               shortEvent    // Short fault seen this cycle
);

  logic swOpenReg;
  logic pulseEnd;
  logic dutyActive;
  logic dutyFull;
  logic shortAllowed;

  // Detection needs a nonzero duty so the switch actually opens
  assign dutyActive   = (duty != '0);
  assign dutyFull     = (duty == DUTY_FULL);
  // Short duty below limit has not settled, so filter it out
  assign shortAllowed = dutyActive && !dutyFull
                        && (duty >= dutyLimit);

  // ---------------------------------------------------------------------
  // Pulse end detection
  // ---------------------------------------------------------------------
  // Previous open phase, for the end-of-pulse edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      swOpenReg <= 1'b0;
    end else if (clkEn) begin
      swOpenReg <= swOpen;
    end
  end

  assign pulseEnd = swOpenReg && !swOpen;

  // Open checked all through the open phase, also at full duty
  assign openEvent  = clkEn && dutyActive && swOpen && openCmp;
  // Short sampled only at pulse end, avoids leading-edge transients
  assign shortEvent = clkEn && shortAllowed && pulseEnd
                      && shortCmp;

  chk_short_at_end: assert property (@(posedge clk) disable iff (!rst_b)
    shortEvent |-> $past(swOpen) && !swOpen)
    else $error("short recorded outside pulse end");

  chk_short_filter: assert property (@(posedge clk) disable iff (!rst_b)
    (duty < dutyLimit) |-> !shortEvent)
    else $error("short passed below duty limit");

endmodule // lfm_switch_qual

// *** lfm_fault_monitor.sv ***
// Fault monitor top: status, masks, bypass, thermal, fault pin
`timescale 1ns/1ns
module lfm_fault_monitor
  import lfm_pkg::*;
#(
  parameter int NSW = NUM_SW,
  parameter int DW  = DUTY_WIDTH
) (
  input  wire logic               clk,          // System clock, 100 MHz
  input  wire logic               rst_b,        // Power-on reset, low
  input  wire logic               clkEn,        // Freezes state when low
  input  wire lfm_req_type        regReq,       // Register request
  output logic [DATA_WIDTH-1:0]   regRdata,     // Read data, registered
  input  wire lfm_rxerr_type      rxErr,        // Receive error pulses
  output logic                    ackEnable,    // Acknowledge allowed
  input  wire logic [NSW*DW-1:0]  dutyVec,      // Duty per switch
  input  wire logic [NSW-1:0]     pwmOpen,      // PWM wants switch open
  input  wire logic [NSW-1:0]     openCmp,      // Open comparators
  input  wire logic [NSW-1:0]     shortCmp,     // Short comparators
  input  wire logic               tempWarn,     // Die above warning
  input  wire logic               tempShdn,     // Die above shutdown
  input  wire logic               tempHyst,     // Die below hysteresis
  input  wire logic               gradeFault,   // Grading pin bad
  output logic [NSW-1:0]          switchOpen,   // Switch drive, 1 open
  output logic                    fault_out_n   // Fault pin, active low
);

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [NSW-1:0]        open_bypass_override_reg;
  logic [DATA_WIDTH-1:0] fault_mask_config_reg;
  logic [DW-1:0]         short_filter_duty_limit_reg;
  logic [NSW-1:0]        short_fault_status_reg;
  logic [NSW-1:0]        open_fault_status_reg;
  logic                  thermal_warning_flag_reg;
  logic                  thermal_shutdown_flag_reg;
  logic                  gradeFlag_reg;
  logic [2:0]            rxErrFlag_reg;
  logic [NSW-1:0]        openLatched_reg;
  lfm_therm_type         thermState_reg;
  logic                  fault_out_n_reg;
  logic [DATA_WIDTH-1:0] regRdata_reg;

  logic [NSW-1:0]        openEvent;
  logic [NSW-1:0]        shortEvent;
  logic [NSW-1:0]        swOpenPhase;
  logic                  wrHit;
  logic                  w1cWarn;
  logic                  w1cShdn;
  logic                  w1cGrade;
  logic [2:0]            w1cRx;
  logic                  fault_out_n_next;
  logic [DATA_WIDTH-1:0] general_status;
  logic                  shdnAction;
  logic                  shdnActive;

  assign wrHit      = regReq.wrEn && clkEn;
  assign shdnAction = fault_mask_config_reg[SHDN_ACTION_BIT];
  assign shdnActive = (thermState_reg == THERM_SHUTDOWN);

  // ---------------------------------------------------------------------
  // Per-switch qualification
  // ---------------------------------------------------------------------
  // Effective open phase: the switch must actually be open for detection
  assign swOpenPhase = switchOpen;

  generate
    for (genvar i = 0; i < NSW; i++) begin : g_sw
      lfm_switch_qual #(.DW(DW)) u_qual (
        .clk        (clk),
        .rst_b      (rst_b),
        .clkEn      (clkEn),
        .duty       (dutyVec[i*DW +: DW]),
        .dutyLimit  (short_filter_duty_limit_reg),
        .swOpen     (swOpenPhase[i]),
        .openCmp    (openCmp[i]),
        .shortCmp   (shortCmp[i]),
        .openEvent  (openEvent[i]),
        .shortEvent (shortEvent[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Host-writable configuration
  // ---------------------------------------------------------------------
  // Configuration writes; these stay live in every thermal state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      open_bypass_override_reg    <= RST_OVERRIDE;
      fault_mask_config_reg       <= RST_MASK;
      short_filter_duty_limit_reg <= RST_DUTY_LIMIT;
    end else if (wrHit) begin
      if (regReq.addr == OFF_OPEN_BYPASS_OVERRIDE) begin
        open_bypass_override_reg <= regReq.wdata[NSW-1:0];
      end
      if (regReq.addr == OFF_FAULT_MASK_CONFIG) begin
        fault_mask_config_reg <= regReq.wdata;
      end
      if (regReq.addr == OFF_SHORT_FILTER_DUTY_LIMIT) begin
        short_filter_duty_limit_reg <= regReq.wdata[DW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Per-switch fault status
  // ---------------------------------------------------------------------
  // Status is sticky until power cycle; there is no software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      open_fault_status_reg  <= '0;
      short_fault_status_reg <= '0;
      openLatched_reg        <= '0;
    end else if (clkEn) begin
      open_fault_status_reg  <= open_fault_status_reg | openEvent;
      short_fault_status_reg <= short_fault_status_reg
                                | shortEvent;
      openLatched_reg        <= openLatched_reg | openEvent;
    end
  end

  // ---------------------------------------------------------------------
  // Switch drive
  // ---------------------------------------------------------------------
  // Shutdown overrides all; open faults and override force closed.
  // Short faults never enter here, so dimming continues as programmed.
  always_comb begin
    if (shdnActive) begin
      switchOpen = {NSW{shdnAction}};
    end else begin
      switchOpen = pwmOpen & ~openLatched_reg
                   & ~open_bypass_override_reg;
    end
  end

  // ---------------------------------------------------------------------
  // Thermal state
  // ---------------------------------------------------------------------
  // Forced state holds until below hysteresis, then prior drive resumes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thermState_reg <= THERM_NORMAL;
    end else if (clkEn) begin
      unique case (thermState_reg)
        THERM_NORMAL: begin
          if (tempShdn) begin
            thermState_reg <= THERM_SHUTDOWN;
          end
        end
        THERM_SHUTDOWN: begin
          if (tempHyst) begin
            thermState_reg <= THERM_NORMAL;
          end
        end
        default: thermState_reg <= THERM_NORMAL;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // General status flags, write-one-to-clear
  // ---------------------------------------------------------------------
  assign w1cWarn  = wrHit && (regReq.addr == OFF_GENERAL_STATUS)
                    && regReq.wdata[STAT_WARN_BIT];
  assign w1cShdn  = wrHit && (regReq.addr == OFF_GENERAL_STATUS)
                    && regReq.wdata[STAT_SHDN_BIT];
  assign w1cGrade = wrHit && (regReq.addr == OFF_GENERAL_STATUS)
                    && regReq.wdata[STAT_GRADE_BIT];
  assign w1cRx    = (wrHit && (regReq.addr == OFF_GENERAL_STATUS))
                    ? regReq.wdata[STAT_STOP_BIT:STAT_CRC_BIT] : 3'b000;

  // Set wins over clear; warning clears only once the die is cool
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_warning_flag_reg  <= 1'b0;
      thermal_shutdown_flag_reg <= 1'b0;
      gradeFlag_reg             <= 1'b0;
      rxErrFlag_reg             <= 3'b000;
    end else if (clkEn) begin
      if (tempWarn) begin
        thermal_warning_flag_reg <= 1'b1;
      end else if (w1cWarn) begin
        thermal_warning_flag_reg <= 1'b0;
      end
      if (tempShdn) begin
        thermal_shutdown_flag_reg <= 1'b1;
      end else if (w1cShdn) begin
        thermal_shutdown_flag_reg <= 1'b0;
      end
      if (gradeFault) begin
        gradeFlag_reg <= 1'b1;
      end else if (w1cGrade) begin
        gradeFlag_reg <= 1'b0;
      end
      rxErrFlag_reg <= (rxErrFlag_reg & ~w1cRx)
                       | {rxErr.stopErr, rxErr.parityErr,
                          rxErr.crcErr};
    end
  end

  // A faulty frame gets no acknowledge
  assign ackEnable = !(rxErr.crcErr || rxErr.parityErr
                       || rxErr.stopErr);

  always_comb begin
    general_status                  = RST_STATUS;
    general_status[STAT_WARN_BIT]   = thermal_warning_flag_reg;
    general_status[STAT_SHDN_BIT]   = thermal_shutdown_flag_reg;
    general_status[STAT_GRADE_BIT]  = gradeFlag_reg;
    general_status[STAT_STOP_BIT:STAT_CRC_BIT] = rxErrFlag_reg;
  end

  // ---------------------------------------------------------------------
  // Fault pin
  // ---------------------------------------------------------------------
  // Open, short, thermal, grading and serial sources, each maskable.
  // Thermal flags clear only when cool, so the pin holds until then.
  always_comb begin
    fault_out_n_next = !(
      ((|open_fault_status_reg)
        && !fault_mask_config_reg[MSK_OPEN_BIT])
      || ((|short_fault_status_reg)
        && !fault_mask_config_reg[MSK_SHORT_BIT])
      || ((thermal_warning_flag_reg || thermal_shutdown_flag_reg
           || tempWarn) && !fault_mask_config_reg[MSK_THERM_BIT])
      || ((gradeFlag_reg || gradeFault)
        && !fault_mask_config_reg[MSK_GRADE_BIT])
      || ((|rxErrFlag_reg)
        && !fault_mask_config_reg[MSK_SERIAL_BIT]));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_out_n_reg <= 1'b1;
    end else if (clkEn) begin
      fault_out_n_reg <= fault_out_n_next;
    end
  end

  assign fault_out_n = fault_out_n_reg;

  // ---------------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------------
  // Unmapped offsets read zero; reads never disturb status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata_reg <= '0;
    end else if (clkEn && regReq.rdEn) begin
      unique case (regReq.addr)
        OFF_OPEN_BYPASS_OVERRIDE:
          regRdata_reg <= DATA_WIDTH'(open_bypass_override_reg);
        OFF_FAULT_MASK_CONFIG:
          regRdata_reg <= fault_mask_config_reg;
        OFF_GENERAL_STATUS:
          regRdata_reg <= general_status;
        OFF_SHORT_FAULT_STATUS:
          regRdata_reg <= DATA_WIDTH'(short_fault_status_reg);
        OFF_OPEN_FAULT_STATUS:
          regRdata_reg <= DATA_WIDTH'(open_fault_status_reg);
        OFF_SHORT_FILTER_DUTY_LIMIT:
          regRdata_reg <= DATA_WIDTH'(short_filter_duty_limit_reg);
        default:
          regRdata_reg <= '0;
      endcase
    end
  end

  assign regRdata = regRdata_reg;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  // Open and short antecedents span every switch, so any faulted lane exercises them
  chk_open_holds_closed: assert property (@(posedge clk) disable iff (!rst_b)
    !shdnActive |-> !(|(switchOpen & openLatched_reg)))
    else $error("open-faulted switch not closed");

  chk_open_status_set: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && (|openEvent)
    |=> (open_fault_status_reg & $past(openEvent)) == $past(openEvent))
    else $error("open status not set");

  chk_warn_pin: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && tempWarn && !fault_mask_config_reg[MSK_THERM_BIT]
    |=> !fault_out_n)
    else $error("thermal warning not on pin");

  chk_open_pin: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && (|open_fault_status_reg)
    && !fault_mask_config_reg[MSK_OPEN_BIT] |=> !fault_out_n)
    else $error("unmasked open fault not on pin");

  chk_short_pin: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && (|short_fault_status_reg)
    && !fault_mask_config_reg[MSK_SHORT_BIT] |=> !fault_out_n)
    else $error("unmasked short fault not on pin");

  chk_warn_hold: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && tempWarn |=> thermal_warning_flag_reg)
    else $error("warning cleared while hot");

  chk_shdn_force: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && tempShdn && !shdnActive
    |=> switchOpen == {NSW{shdnAction}})
    else $error("shutdown did not force switches");

  chk_shdn_resume: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && shdnActive && tempHyst |=> !shdnActive)
    else $error("shutdown did not release");

  chk_rx_no_ack: assert property (@(posedge clk) disable iff (!rst_b)
    rxErr.crcErr |-> !ackEnable
    ##1 (!$past(clkEn) || rxErrFlag_reg[0]))
    else $error("crc error acknowledged or not flagged");

endmodule // lfm_fault_monitor

// *** lfm_host_model.sv ***
// Host model: register reads and writes at the block's register port
`timescale 1ns/1ns
module lfm_host_model
  import lfm_pkg::*;
(
  input  wire logic                  clk,      // System clock
  output lfm_req_type                regReq,   // Register request
  input  wire logic [DATA_WIDTH-1:0] regRdata  // Registered read data
);
  // -------------------------------------------------------------------
  // Bus tasks
  // -------------------------------------------------------------------
  // Idle bus shows inverted fields so a stale copy is never mistaken
  initial regReq = '0;

  // One write, one request cycle, changes only just after an edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    regReq <= '{1'b0, 1'b0, ~a, ~d};
  endtask

  // One read, data taken once the request edge has landed
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regReq <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    regReq <= '{1'b0, 1'b0, ~a, 16'hFFFF};
    #1 d = regRdata;
  endtask
endmodule // lfm_host_model

// *** lfm_fault_monitor_tb_top.sv ***
// Self-checking testbench for the LED matrix fault monitor
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  failCount++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module lfm_fault_monitor_tb_top;
  import lfm_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [15:0] d;} lfm_row_type;
  // -------------------------------------------------------------------
  // Signals and instances
  // -------------------------------------------------------------------
  logic            clk = 0, rst_b = 0, clkEn = 1;
  logic            tempWarn = 0, tempShdn = 0, tempHyst = 1;
  logic            gradeFault = 0, ackEnable, fault_out_n;
  logic [143:0]    dutyVec;
  logic [11:0]     pwmOpen = 0, openCmp = 0, shortCmp = 0, switchOpen;
  logic [15:0]     regRdata, v;
  lfm_req_type     regReq;
  lfm_rxerr_type   rxErr = '0;
  int              failCount = 0, checks = 0;
  lfm_row_type     rows [12];

  always #5 clk = ~clk;

  lfm_host_model host (.clk(clk), .regReq(regReq), .regRdata(regRdata));
  lfm_fault_monitor dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .regReq(regReq), .regRdata(regRdata), .rxErr(rxErr),
    .ackEnable(ackEnable), .dutyVec(dutyVec), .pwmOpen(pwmOpen),
    .openCmp(openCmp), .shortCmp(shortCmp), .tempWarn(tempWarn),
    .tempShdn(tempShdn), .tempHyst(tempHyst), .gradeFault(gradeFault),
    .switchOpen(switchOpen), .fault_out_n(fault_out_n));

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Sample one time unit past the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    failCount++;
    report_and_stop();
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    // Sw0 mid duty, sw1 below limit, sw2 full, sw3 zero
    dutyVec = {{8{12'h800}}, 12'h000, 12'hFFF, 12'h008, 12'h800};
    rows = '{'{0, 8'h0C, RST_MASK}, '{0, 8'h09, {4'h0, RST_OVERRIDE}},
      '{0, 8'h16, {4'h0, RST_DUTY_LIMIT}}, '{1, 8'h12, 16'hFFFF},
      '{0, 8'h12, 16'h0000}, '{1, 8'h16, 16'h0010},
      '{0, 8'h16, 16'h0010}, '{1, 8'h09, 16'h0800},
      '{0, 8'h09, 16'h0800}, '{0, 8'h20, 16'h0000},
      '{1, 8'h0C, 16'h001F}, '{0, 8'h0C, 16'h001F}};
    repeat (12) @(posedge clk);
    rst_b <= 1;
    tick(1);
    `CHK("pin after reset", 1'b1, fault_out_n)
    foreach (rows[i]) begin
      if (rows[i].w) host.wr(rows[i].a, rows[i].d);
      else begin
        host.rd(rows[i].a, v);
        `CHK("register row", rows[i].d, v)
      end
    end
    host.wr(8'h0C, 16'h0000);
    // Short pulse; sw4 comparator drops before the pulse ends
    @(posedge clk);
    shortCmp <= 12'h01F;
    pwmOpen  <= 12'h01F;
    tick(2);
    `CHK("switches dimming", 12'h01F, switchOpen)
    shortCmp <= 12'h00F;
    @(posedge clk);
    pwmOpen <= 12'h000;
    tick(4);
    host.rd(8'h12, v);
    `CHK("short status", 16'h0001, v)
    `CHK("pin on short", 1'b0, fault_out_n)
    shortCmp <= 12'h000;
    host.wr(8'h0C, 16'h0002);
    tick(4);
    `CHK("pin short masked", 1'b1, fault_out_n)
    // Open on sw2 at full duty, sw3 at zero duty is ignored
    pwmOpen <= 12'h00C;
    openCmp <= 12'h00C;
    tick(4);
    host.rd(8'h13, v);
    `CHK("open status", 16'h0004, v)
    `CHK("open bypass", 12'h008, switchOpen)
    `CHK("pin on open", 1'b0, fault_out_n)
    openCmp <= 12'h000;
    host.wr(8'h0C, 16'h0003);
    tick(4);
    `CHK("pin open masked", 1'b1, fault_out_n)
    // Warning: clear refused while hot, accepted once cool
    tempWarn <= 1'b1;
    tick(4);
    `CHK("pin on warning", 1'b0, fault_out_n)
    `CHK("switches on warning", 12'h008, switchOpen)
    host.wr(8'h10, 16'h0001);
    host.rd(8'h10, v);
    `CHK("warn held hot", 16'h0001, v)
    tempWarn <= 1'b0;
    tick(4);
    `CHK("pin until cleared", 1'b0, fault_out_n)
    host.wr(8'h10, 16'h0001);
    tick(4);
    `CHK("pin warn cleared", 1'b1, fault_out_n)
    // Shutdown with both actions, then recovery through hysteresis
    for (int a = 0; a < 2; a++) begin
      host.wr(8'h0C, a ? 16'h0023 : 16'h0003);
      tempWarn <= 1'b1;
      tempShdn <= 1'b1;
      tempHyst <= 1'b0;
      tick(4);
      `CHK("forced switches", {12{a[0]}}, switchOpen)
      host.rd(8'h10, v);
      `CHK("thermal flags", 16'h0003, v)
      tempShdn <= 1'b0;
      tick(4);
      `CHK("forced held", {12{a[0]}}, switchOpen)
      `CHK("pin in shutdown", 1'b0, fault_out_n)
      tempHyst <= 1'b1;
      tempWarn <= 1'b0;
      tick(4);
      `CHK("resumed switches", 12'h008, switchOpen)
      `CHK("pin before clear", 1'b0, fault_out_n)
      host.wr(8'h10, 16'h0003);
      tick(4);
      `CHK("pin thermal clear", 1'b1, fault_out_n)
    end
    // Each serial receive error, one pulse at a time
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      rxErr <= 3'b100 >> i;
      #1;
      `CHK("no acknowledge", 1'b0, ackEnable)
      @(posedge clk);
      rxErr <= '0;
      tick(3);
      `CHK("acknowledge idle", 1'b1, ackEnable)
      host.rd(8'h10, v);
      `CHK("serial flag", 16'h0008 << i, v)
      `CHK("pin on serial", 1'b0, fault_out_n)
      host.wr(8'h10, 16'h0038);
      tick(4);
      `CHK("pin serial clear", 1'b1, fault_out_n)
    end
    // Frozen block must not flag an error pulse or drive the pin; ackEnable still drops
    clkEn <= 1'b0;
    rxErr <= 3'b100;
    tick(2);
    `CHK("pin frozen", 1'b1, fault_out_n)
    rxErr <= '0;
    clkEn <= 1'b1;
    host.rd(8'h10, v);
    `CHK("frozen no flag", 16'h0000, v)
    // Grading pin fault
    gradeFault <= 1'b1;
    tick(4);
    `CHK("pin on grading", 1'b0, fault_out_n)
    host.rd(8'h10, v);
    `CHK("grading flag", 16'h0004, v)
    report_and_stop();
  end
endmodule // lfm_fault_monitor_tb_top
